//--- rtl/bfsc_unit.sv
// Character-serial datapath for field subtract and field compare.
// Assumes a storage port that answers each held request with one mem_ack
// pulse; on a read the character is valid on mem_rdata in that cycle.
//
// Notes on behaviour
// - Subtract field A from field C, low end first, difference into C.
// - Lowest character holds sign; difference sign lands in C's lowest.
// - Codes twelve to seventeen octal count as zero before arithmetic.
// - Subtract condition is 00 for positive and 10 for negative.
// - First variant never leaves a negative zero.
// - Count index tracks field C characters during subtract.
// - Decimal fault on carry out, bad lengths, zones, digits, signs.
// - Second variant may stop once A is used up under three conditions.
// - Second variant reads blank as zero in both fields.
// - Second variant rewrites sign forty octal as fifty-two.
// - Second variant zero result is always positive.
// - Compare scans from the high end; inequality exits to P plus 3.
// - Leftover of longer field all blank means equal, exit P plus 4.
// - Non-blank leftover: longer A gives greater, longer C gives less.
// - Compare condition is 00 equal, 01 greater, 10 less.
// - First variant compare leaves C character count in count index.
// - Second variant ranks unequal characters through the table.
// - Table of 64 ranks in storage is loaded by software, only read.
// - Table address is the code plus fixed base two hundred octal.
// - Ranks are compared; equal ranks fall back to the raw codes.
// - Second variant ends on inequality or exhaustion, count kept.
`timescale 1ns/1ns
module bfsc_unit
    import bfsc_pkg::*;
#(
    parameter bit VARIANT2 = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic              op_compare,
    input  wire logic [ADDR_W-1:0] addr_a,
    input  wire logic [ADDR_W-1:0] addr_c,
    input  wire logic [LEN_W-1:0]  field_a_length,
    input  wire logic [LEN_W-1:0]  field_c_length,
    input  wire logic              mem_ack,
    input  wire logic [5:0]        mem_rdata,
    output logic                   busy,
    output logic                   done,
    output logic      [1:0]        cond_code,
    output logic      [LEN_W-1:0]  count_index_reg,
    output logic                   fault,
    output logic      [2:0]        next_word_offset,
    output logic                   mem_req,
    output logic                   mem_we,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic      [5:0]        mem_wdata
);

    // ==========================================================
    // Helpers

    function automatic logic [ADDR_W-1:0] field_addr(
        input logic [ADDR_W-1:0] base,
        input logic [LEN_W-1:0]  idx,
        input logic              up
    );
        logic [ADDR_W-1:0] off;
        off = {8'h00, idx};
        field_addr = up ? (base + off) : (base - off);
    endfunction : field_addr

    function automatic bfsc_regs_t issue(
        input bfsc_regs_t        s,
        input logic              we,
        input logic [ADDR_W-1:0] addr,
        input logic [5:0]        data
    );
        issue           = s;
        issue.mem_req   = 1'b1;
        issue.mem_we    = we;
        issue.mem_addr  = addr;
        issue.mem_wdata = data;
    endfunction : issue

    function automatic bfsc_regs_t finish(
        input bfsc_regs_t s,
        input logic [1:0] cond,
        input logic [2:0] off
    );
        finish          = s;
        finish.cond     = cond;
        finish.next_off = off;
        finish.done     = 1'b1;
        finish.busy     = 1'b0;
        finish.fsm      = ST_DONE;
    endfunction : finish

    // ==========================================================
    // Datapath

    bfsc_regs_t        r_reg;
    bfsc_regs_t        r_next;
    logic              first_char;
    logic [3:0]        chk_digit;
    logic              chk_neg;
    logic              chk_bad;
    logic              c_neg_now;
    logic              same_sign_now;
    logic              same_sign;
    logic              rec;
    logic [3:0]        alu_x;
    logic [3:0]        alu_y;
    logic              alu_sub;
    logic [3:0]        alu_res;
    logic              alu_cout;
    logic [LEN_W-1:0]  idx_inc;
    logic [LEN_W-1:0]  len_max;
    logic              c_have;
    logic [5:0]        c_now;
    logic              acked;
    logic              neg_res;
    logic [5:0]        sign_raw;
    logic [5:0]        sign_ch;

    assign first_char    = (r_reg.idx == LEN_ZERO);
    assign c_neg_now     = first_char ? chk_neg : r_reg.c_neg;
    assign same_sign_now = (r_reg.a_neg == c_neg_now);
    assign same_sign     = (r_reg.a_neg == r_reg.c_neg);
    assign rec           = (r_reg.fsm == ST_REC_RDC);
    // Like signs mean C minus A on magnitudes; unlike signs add them.
    assign alu_x   = rec ? DIGIT_ZERO : chk_digit;
    assign alu_y   = rec ? chk_digit : r_reg.a_dig;
    assign alu_sub = rec | same_sign_now;
    assign idx_inc = r_reg.idx + LEN_ONE;
    assign len_max = (r_reg.len_a > r_reg.len_c) ? r_reg.len_a : r_reg.len_c;
    assign c_have  = (r_reg.idx < r_reg.len_c);
    assign c_now   = c_have ? mem_rdata : CODE_BLANK;
    assign acked   = r_reg.mem_req & mem_ack;
    assign neg_res = r_reg.c_neg & r_reg.nonzero;
    assign sign_raw = {neg_res ? ZONE_NEG : ZONE_POS, r_reg.low_dig};
    assign sign_ch  = (VARIANT2 && sign_raw == CODE_NEG_ZERO_IN) ?
                      CODE_NEG_ZERO_TAPE : sign_raw;

    bfsc_char_check #(
        .VARIANT2 (VARIANT2)
    ) u_check (
        .ch      (mem_rdata),
        .is_sign (first_char),
        .digit   (chk_digit),
        .neg     (chk_neg),
        .bad     (chk_bad)
    );

    bfsc_digit_alu u_alu (
        .x    (alu_x),
        .y    (alu_y),
        .cin  (r_reg.borrow),
        .sub  (alu_sub),
        .res  (alu_res),
        .cout (alu_cout)
    );

    // ==========================================================
    // Sequencer

    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        case (r_reg.fsm)
            ST_IDLE: begin
                if (start) begin
                    r_next         = REGS_RST;
                    r_next.busy    = 1'b1;
                    r_next.base_a  = addr_a;
                    r_next.base_c  = addr_c;
                    r_next.len_a   = field_a_length;
                    r_next.len_c   = field_c_length;
                    r_next.cond    = r_reg.cond;
                    if (op_compare) begin
                        r_next.fsm = ST_CMP_RDA;
                    end else begin
                        // A too long is flagged but the walk still runs.
                        r_next.fault = (field_a_length > field_c_length);
                        if (field_c_length == LEN_ZERO) begin
                            r_next = finish(r_next, COND_POS, NEXT_P3);
                        end else begin
                            r_next.fsm = ST_SUB_RDA;
                        end
                    end
                end
            end
            ST_SUB_RDA: begin
                if (r_reg.idx >= r_reg.len_a) begin
                    r_next.a_dig = DIGIT_ZERO;
                    r_next.fsm   = ST_SUB_RDC;
                end else if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b0,
                        field_addr(r_reg.base_a, r_reg.idx, 1'b0), CODE_ZERO);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.a_dig   = chk_digit;
                    if (first_char) begin
                        r_next.a_neg = chk_neg;
                    end
                    r_next.fault = r_reg.fault | chk_bad;
                    r_next.fsm   = ST_SUB_RDC;
                end
            end
            ST_SUB_RDC: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b0,
                        field_addr(r_reg.base_c, r_reg.idx, 1'b0), CODE_ZERO);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.c_neg   = c_neg_now;
                    r_next.fault   = r_reg.fault | chk_bad;
                    r_next.c_dig   = alu_res;
                    r_next.borrow  = alu_cout;
                    r_next.nonzero = r_reg.nonzero | (alu_res != DIGIT_ZERO);
                    if (first_char) begin
                        r_next.low_dig = alu_res;
                    end
                    r_next.cnt = idx_inc;
                    r_next.fsm = ST_SUB_WRC;
                end
            end
            ST_SUB_WRC: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b1,
                        field_addr(r_reg.base_c, r_reg.idx, 1'b0),
                        {ZONE_POS, r_reg.c_dig});
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.idx     = idx_inc;
                    if (idx_inc == r_reg.len_c) begin
                        if (same_sign && r_reg.borrow) begin
                            // C was smaller: complement it back, flip sign.
                            r_next.idx    = LEN_ZERO;
                            r_next.borrow = 1'b0;
                            r_next.c_neg  = ~r_reg.c_neg;
                            r_next.fsm    = ST_REC_RDC;
                        end else begin
                            if (!same_sign && r_reg.borrow) begin
                                r_next.fault = 1'b1;
                            end
                            r_next.fsm = ST_SUB_SIGN;
                        end
                    end else if (VARIANT2 && idx_inc >= r_reg.len_a &&
                                 same_sign && !r_reg.borrow &&
                                 r_reg.nonzero) begin
                        r_next.fsm = ST_SUB_SIGN;
                    end else begin
                        r_next.fsm = ST_SUB_RDA;
                    end
                end
            end
            ST_REC_RDC: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b0,
                        field_addr(r_reg.base_c, r_reg.idx, 1'b0), CODE_ZERO);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.c_dig   = alu_res;
                    r_next.borrow  = alu_cout;
                    if (first_char) begin
                        r_next.low_dig = alu_res;
                    end
                    r_next.fsm = ST_REC_WRC;
                end
            end
            ST_REC_WRC: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b1,
                        field_addr(r_reg.base_c, r_reg.idx, 1'b0),
                        {ZONE_POS, r_reg.c_dig});
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.idx     = idx_inc;
                    r_next.fsm     = (idx_inc == r_reg.len_c) ?
                                     ST_SUB_SIGN : ST_REC_RDC;
                end
            end
            ST_SUB_SIGN: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b1, r_reg.base_c, sign_ch);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next = finish(r_next, neg_res ? COND_NEG : COND_POS,
                                    NEXT_P3);
                end
            end
            ST_CMP_RDA: begin
                if (r_reg.idx >= r_reg.len_a) begin
                    r_next.a_ch = CODE_BLANK;
                    r_next.fsm  = ST_CMP_RDC;
                end else if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b0,
                        field_addr(r_reg.base_a, r_reg.idx, 1'b1), CODE_ZERO);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.a_ch    = mem_rdata;
                    r_next.fsm     = ST_CMP_RDC;
                end
            end
            ST_CMP_RDC: begin
                if (c_have && !acked) begin
                    if (!r_reg.mem_req) begin
                        r_next = issue(r_reg, 1'b0,
                            field_addr(r_reg.base_c, r_reg.idx, 1'b1),
                            CODE_ZERO);
                    end
                end else begin
                    r_next.mem_req = 1'b0;
                    r_next.c_ch    = c_now;
                    if (c_have) begin
                        r_next.cnt = idx_inc;
                    end
                    if (r_reg.a_ch != c_now) begin
                        if (r_reg.idx >= r_reg.len_a) begin
                            r_next = finish(r_next, COND_LT, NEXT_P3);
                        end else if (!c_have) begin
                            r_next = finish(r_next, COND_GT, NEXT_P3);
                        end else if (VARIANT2) begin
                            r_next.fsm = ST_CMP_RKA;
                        end else begin
                            r_next = finish(r_next,
                                (r_reg.a_ch > c_now) ? COND_GT : COND_LT,
                                NEXT_P3);
                        end
                    end else if (idx_inc >= len_max) begin
                        r_next = finish(r_next, COND_EQ, NEXT_P4);
                    end else begin
                        r_next.idx = idx_inc;
                        r_next.fsm = ST_CMP_RDA;
                    end
                end
            end
            ST_CMP_RKA: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b0,
                        COLL_BASE + {14'h0000, r_reg.a_ch}, CODE_ZERO);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    r_next.rank_a  = mem_rdata;
                    r_next.fsm     = ST_CMP_RKC;
                end
            end
            ST_CMP_RKC: begin
                if (!r_reg.mem_req) begin
                    r_next = issue(r_reg, 1'b0,
                        COLL_BASE + {14'h0000, r_reg.c_ch}, CODE_ZERO);
                end else if (mem_ack) begin
                    r_next.mem_req = 1'b0;
                    // Equal ranks fall back to the raw codes.
                    if (r_reg.rank_a != mem_rdata) begin
                        r_next = finish(r_next,
                            (r_reg.rank_a > mem_rdata) ? COND_GT : COND_LT,
                            NEXT_P3);
                    end else begin
                        r_next = finish(r_next,
                            (r_reg.a_ch > r_reg.c_ch) ? COND_GT : COND_LT,
                            NEXT_P3);
                    end
                end
            end
            ST_DONE: begin
                r_next.fsm = ST_IDLE;
            end
            default: begin
                r_next = REGS_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs

    assign busy             = r_reg.busy;
    assign done             = r_reg.done;
    assign cond_code        = r_reg.cond;
    assign count_index_reg  = r_reg.cnt;
    assign fault            = r_reg.fault;
    assign next_word_offset = r_reg.next_off;
    assign mem_req          = r_reg.mem_req;
    assign mem_we           = r_reg.mem_we;
    assign mem_addr         = r_reg.mem_addr;
    assign mem_wdata        = r_reg.mem_wdata;

endmodule : bfsc_unit

//--- rtl/bfsc_pkg.sv
// Shared constants and state types of the field subtract and compare unit.
// Assumes a character-addressed core storage port with six-bit characters.
package bfsc_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 20;
    localparam int LEN_W  = 12;
    localparam int CHAR_W = 6;

    // ==========================================================
    // Character codes
    localparam logic [5:0] CODE_ZERO          = 6'h00;
    localparam logic [5:0] CODE_BLANK         = 6'h30;
    localparam logic [5:0] CODE_BAD_SIGN      = 6'h3A;
    localparam logic [5:0] CODE_NEG_ZERO_IN   = 6'h20;
    localparam logic [5:0] CODE_NEG_ZERO_TAPE = 6'h2A;
    localparam logic [3:0] DIGIT_MAX          = 4'h9;
    localparam logic [3:0] SIGN_DIGIT_MAX     = 4'hA;
    localparam logic [3:0] DIGIT_ZERO         = 4'h0;
    localparam logic [3:0] DEC_ADJ            = 4'hA;
    localparam logic [4:0] DEC_BASE           = 5'h0A;
    localparam logic [1:0] ZONE_POS           = 2'h0;
    localparam logic [1:0] ZONE_NEG           = 2'h2;

    // ==========================================================
    // Collating table and outcomes
    localparam logic [ADDR_W-1:0] COLL_BASE = 20'h00080;
    localparam logic [1:0] COND_EQ  = 2'h0;
    localparam logic [1:0] COND_POS = 2'h0;
    localparam logic [1:0] COND_GT  = 2'h1;
    localparam logic [1:0] COND_LT  = 2'h2;
    localparam logic [1:0] COND_NEG = 2'h2;
    localparam logic [2:0] NEXT_P3  = 3'h3;
    localparam logic [2:0] NEXT_P4  = 3'h4;
    localparam logic [LEN_W-1:0] LEN_ZERO = 12'h000;
    localparam logic [LEN_W-1:0] LEN_ONE  = 12'h001;

    // ==========================================================
    // Sequencer state
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_SUB_RDA  = 4'h1,
        ST_SUB_RDC  = 4'h2,
        ST_SUB_WRC  = 4'h3,
        ST_REC_RDC  = 4'h4,
        ST_REC_WRC  = 4'h5,
        ST_SUB_SIGN = 4'h6,
        ST_CMP_RDA  = 4'h7,
        ST_CMP_RDC  = 4'h8,
        ST_CMP_RKA  = 4'h9,
        ST_CMP_RKC  = 4'hA,
        ST_DONE     = 4'hB
    } bfsc_fsm_t;

    typedef struct packed {
        bfsc_fsm_t         fsm;
        logic [ADDR_W-1:0] base_a;
        logic [ADDR_W-1:0] base_c;
        logic [LEN_W-1:0]  len_a;
        logic [LEN_W-1:0]  len_c;
        logic [LEN_W-1:0]  idx;
        logic [LEN_W-1:0]  cnt;
        logic [3:0]        a_dig;
        logic [3:0]        c_dig;
        logic [3:0]        low_dig;
        logic              a_neg;
        logic              c_neg;
        logic              borrow;
        logic              nonzero;
        logic [5:0]        a_ch;
        logic [5:0]        c_ch;
        logic [5:0]        rank_a;
        logic [1:0]        cond;
        logic              fault;
        logic              busy;
        logic              done;
        logic [2:0]        next_off;
        logic              mem_req;
        logic              mem_we;
        logic [ADDR_W-1:0] mem_addr;
        logic [5:0]        mem_wdata;
    } bfsc_regs_t;

    // Enum code 0 is ST_IDLE, so all-zero is the reset state.
    localparam bfsc_regs_t REGS_RST = '0;

endpackage : bfsc_pkg

//--- rtl/bfsc_char_check.sv
// Classifies one operand character read from storage.
// Assumes the caller tells it whether the character is a sign position.
`timescale 1ns/1ns
module bfsc_char_check
    import bfsc_pkg::*;
#(
    parameter bit VARIANT2 = 1'b0
) (
    input  wire logic [5:0] ch,
    input  wire logic       is_sign,
    output logic      [3:0] digit,
    output logic            neg,
    output logic            bad
);

    logic [5:0] code;

    always_comb begin
        code = ch;
        if (VARIANT2 && ch == CODE_BLANK) begin
            code = CODE_ZERO;
        end
        // Illegal numerics still count as zero so the walk can go on.
        digit = (code[3:0] > DIGIT_MAX) ? DIGIT_ZERO : code[3:0];
        neg   = is_sign && (code[5:4] == ZONE_NEG);
        if (is_sign) begin
            bad = (code[3:0] > SIGN_DIGIT_MAX) || (code == CODE_BAD_SIGN);
        end else begin
            bad = (code[5:4] != ZONE_POS) || (code[3:0] > DIGIT_MAX);
        end
    end

endmodule : bfsc_char_check

//--- rtl/bfsc_digit_alu.sv
// One decimal digit adder and subtractor with carry or borrow.
// Assumes both operand digits are already in the range 0 to 9.
`timescale 1ns/1ns
module bfsc_digit_alu
    import bfsc_pkg::*;
(
    input  wire logic [3:0] x,
    input  wire logic [3:0] y,
    input  wire logic       cin,
    input  wire logic       sub,
    output logic      [3:0] res,
    output logic            cout
);

    logic [4:0] t;

    always_comb begin
        if (sub) begin
            t    = {1'b0, x} - {1'b0, y} - {4'h0, cin};
            cout = t[4];
            res  = t[4] ? (t[3:0] + DEC_ADJ) : t[3:0];
        end else begin
            t    = {1'b0, x} + {1'b0, y} + {4'h0, cin};
            cout = (t >= DEC_BASE);
            res  = cout ? 4'(t - DEC_BASE) : t[3:0];
        end
    end

endmodule : bfsc_digit_alu

//--- testbench/bfsc_unit_assertions.sv
// Property checker for the field subtract and compare unit.
// Sees only top-level ports; bound in from the bench top file.
`timescale 1ns/1ns
module bfsc_unit_assertions
    import bfsc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              start,
    input wire logic              mem_ack,
    input wire logic              busy,
    input wire logic              done,
    input wire logic [1:0]        cond_code,
    input wire logic [2:0]        next_word_offset,
    input wire logic              mem_req,
    input wire logic              mem_we,
    input wire logic [ADDR_W-1:0] mem_addr
);
    // ====================================================
    // Storage port and command handshakes
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wait; mem_req && !mem_ack; endsequence
    sequence s_acked; mem_req && mem_ack; endsequence
    AST_HOLD: assert property (s_wait |=> mem_req && $stable(mem_addr)
        && $stable(mem_we)) else $error("request moved before ack");
    AST_DROP: assert property (s_acked |=> !mem_req)
        else $error("request held after ack");
    AST_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_FALL: assert property ($fell(busy) |-> done)
        else $error("busy fell without done");
    AST_GO: assert property (start && !busy && !done |=> busy || done)
        else $error("start not taken");
    AST_COND: assert property (done |-> cond_code != 2'h3)
        else $error("illegal condition code");
    AST_EQ: assert property (done && next_word_offset == NEXT_P4
        |-> cond_code == COND_EQ) else $error("P+4 exit without equal");
    AST_IDLE: assert property (!busy |-> !mem_req)
        else $error("storage access while idle");
endmodule : bfsc_unit_assertions

//--- testbench/bfsc_mem_model.sv
// Core storage model answering the unit's storage port.
// Bench preloads fields and the rank table through mem.
`timescale 1ns/1ns
module bfsc_mem_model (
    input  wire logic        clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [19:0] mem_addr,
    input  wire logic [5:0]  mem_wdata,
    output logic             mem_ack,
    output logic      [5:0]  mem_rdata
);
    // ====================================================
    // Storage array with a random answer delay
    logic [5:0] mem [0:511];
    logic [1:0] dly = 2'h0;
    // Inverse data outside an ack so a stale read never matches.
    assign mem_rdata = mem_ack ? mem[mem_addr[8:0]] : ~mem[mem_addr[8:0]];
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        if (mem_req && !mem_ack) begin
            if (dly == 2'h0) begin
                mem_ack <= 1'b1;
                dly <= 2'($urandom % 3);
                if (mem_we)
                    mem[mem_addr[8:0]] <= mem_wdata;
            end else
                dly <= dly - 2'h1;
        end
    end
endmodule : bfsc_mem_model

//--- testbench/bfsc_unit_tb.sv
// Self-checking bench for the unit in its second model variant.
// Storage comes from bfsc_mem_model; the checker is bound below.
`timescale 1ns/1ns
module bfsc_unit_tb;
    import bfsc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, op_compare = 1'b0;
    logic [ADDR_W-1:0] addr_a = '0, addr_c = '0, mem_addr;
    logic [LEN_W-1:0] field_a_length = '0, field_c_length = '0;
    logic [LEN_W-1:0] count_index_reg;
    logic mem_ack, busy, done, fault, mem_req, mem_we;
    logic [5:0] mem_rdata, mem_wdata;
    logic [1:0] cond_code;
    logic [2:0] next_word_offset;
    logic [16:0] notes[$];
    int n_errors = 0, num_checks = 0, cyc = 0;
    bfsc_unit #(.VARIANT2(1'b1)) dut_u (.*);
    bfsc_mem_model mem_u (.*);
    // ====================================================
    // Compare, drive and report
    task automatic cmp(logic [16:0] g, logic [16:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic chk_ch(logic [5:0] g, logic [5:0] e);
        cmp({11'h0, g}, {11'h0, e});
    endtask : chk_ch
    task automatic run(logic c, int a, int s, int la, int lc, logic [16:0] e);
        notes.push_back(e);
        @(posedge clk);
        start <= 1'b1;
        op_compare <= c;
        addr_a <= 20'(a);
        addr_c <= 20'(s);
        field_a_length <= 12'(la);
        field_c_length <= 12'(lc);
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
    endtask : run
    task automatic final_report();
        // A run whose done never came leaves its note behind.
        if (notes.size() != 0)
            n_errors++;
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        if (done === 1'b1 && notes.size() > 0)
            cmp({cond_code, count_index_reg, next_word_offset},
                notes.pop_front());
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        void'($urandom(78));
        foreach (mem_u.mem[i]) mem_u.mem[i] = CODE_BLANK;
        for (int i = 0; i < 64; i++) mem_u.mem[128 + i] = 6'(i);
        // Two ranks reversed so raw codes would give the wrong answer.
        mem_u.mem[135] = 6'h17;
        mem_u.mem[172] = 6'h0A;
        for (int i = 0; i < 3; i++) begin
            mem_u.mem[256 + i] = 6'($urandom);
            mem_u.mem[320 + i] = mem_u.mem[256 + i];
        end
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        run(1, 256, 320, 3, 3, {COND_EQ, 12'd3, NEXT_P4});
        run(1, 256, 320, 4, 3, {COND_EQ, 12'd3, NEXT_P4});
        mem_u.mem[323] = 6'h01;
        mem_u.mem[260] = 6'h01;
        run(1, 256, 320, 3, 4, {COND_LT, 12'd4, NEXT_P3});
        run(1, 256, 320, 5, 3, {COND_GT, 12'd3, NEXT_P3});
        mem_u.mem[257] = 6'h07;
        mem_u.mem[321] = 6'h2C;
        run(1, 256, 320, 3, 3, {COND_GT, 12'd2, NEXT_P3});
        mem_u.mem[448] = 6'h01;
        mem_u.mem[449] = 6'h05;
        mem_u.mem[384] = 6'h03;
        run(0, 384, 449, 1, 2, {COND_POS, 12'd1, NEXT_P3});
        chk_ch(mem_u.mem[449], 6'h02);
        chk_ch(mem_u.mem[448], 6'h01);
        mem_u.mem[464] = 6'h23;
        mem_u.mem[385] = 6'h05;
        run(0, 385, 464, 1, 1, {COND_NEG, 12'd1, NEXT_P3});
        chk_ch(mem_u.mem[464], 6'h28);
        cmp({16'h0, fault}, 17'h0);
        mem_u.mem[386] = 6'h0C;
        run(0, 386, 480, 1, 1, {COND_POS, 12'd1, NEXT_P3});
        chk_ch(mem_u.mem[480], CODE_ZERO);
        cmp({16'h0, fault}, 17'h1);
        final_report();
    end
endmodule : bfsc_unit_tb
bind bfsc_unit bfsc_unit_assertions chk_u (.*);
